// [ccms_regs.svh]
// register indices, bit positions, reset values and fixed counts of the mode select block
`ifndef CCMS_REGS_SVH
`define CCMS_REGS_SVH
`define CCMS_IDX_MODE0 8'he3
`define CCMS_IDX_MODE1 8'he4
`define CCMS_IDX_OFS_LO 8'he6
`define CCMS_IDX_OFS_HI 8'he7
`define CCMS_BYTE_ADDR(idx) {2'h0, (idx), 2'h0}
`define CCMS_RST_BYTE 8'h00
`define CCMS_RST_WORD 16'h0000
`define CCMS_TMR_ZERO 16'h0000
`define CCMS_RD_PAD 24'h00_0000
`define CCMS_CH_W 4
`define CCMS_B_MODSEL 3
`define CCMS_B_SWMC 4
`define CCMS_B_NEXT 5
`define CCMS_MODE1_MASK 8'h3f
`define CCMS_PHASE_4 3'h4
`define CCMS_PHASE_5 3'h5
`endif

// [ccms_pkg.sv]
// shared types and decode functions of the mode select block
`include "ccms_regs.svh"
package ccms_pkg;
  typedef enum logic [2:0] {
    CCMS_OFF = 3'h0,
    CCMS_CMP_PRI = 3'h1,
    CCMS_CMP_COMPL = 3'h2,
    CCMS_CMP_BOTH = 3'h3,
    CCMS_CAP_NONE = 3'h4,
    CCMS_CAP_RISE = 3'h5,
    CCMS_CAP_FALL = 3'h6,
    CCMS_CAP_BOTH = 3'h7
  } ccms_mode_e;

  typedef enum logic [1:0] {
    CCMS_APB_IDLE = 2'h1,
    CCMS_APB_ACC = 2'h2
  } ccms_apb_e;

  typedef enum logic [5:0] {
    CCMS_MC_S0 = 6'h01,
    CCMS_MC_S1 = 6'h02,
    CCMS_MC_S2 = 6'h04,
    CCMS_MC_S3 = 6'h08,
    CCMS_MC_S4 = 6'h10,
    CCMS_MC_S5 = 6'h20
  } ccms_mc_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ccms_apb_req_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ccms_apb_rsp_s;

  typedef struct packed {
    logic [15:0] value;
    logic period_hit;
    logic zero_hit;
    logic count_mode;
    logic start;
    logic shadow_en;
  } ccms_tmr_s;

  typedef struct packed {
    logic pri_o;
    logic pri_oe;
    logic compl_o;
    logic compl_oe;
  } ccms_pin_s;

  typedef struct packed {
    logic stb;
    logic [15:0] value;
  } ccms_cap_s;

  typedef struct packed {
    logic pin_prev;
    logic init_lvl;
    ccms_pin_s pin;
    ccms_cap_s cap;
  } ccms_chan_s;

  typedef struct packed {
    ccms_apb_e apb;
    ccms_apb_rsp_s rsp;
    logic [7:0] mode0;
    logic [7:0] mode1;
    logic [15:0] ofs_sh;
    logic [15:0] ofs_wk;
    logic [15:0] sum;
    ccms_mc_e mc;
    logic mc_pend;
  } ccms_top_s;

  function automatic logic drives_pri(input ccms_mode_e m);
    return (m == CCMS_CMP_PRI) || (m == CCMS_CMP_BOTH);
  endfunction

  function automatic logic drives_compl(input ccms_mode_e m);
    return (m == CCMS_CMP_COMPL) || (m == CCMS_CMP_BOTH);
  endfunction

  function automatic ccms_mc_e mc_next(input ccms_mc_e s, input logic [2:0] phases);
    case (s)
      CCMS_MC_S0: return CCMS_MC_S1;
      CCMS_MC_S1: return CCMS_MC_S2;
      CCMS_MC_S2: return CCMS_MC_S3;
      CCMS_MC_S3: return (phases == `CCMS_PHASE_4) ? CCMS_MC_S0 : CCMS_MC_S4;
      CCMS_MC_S4: return (phases == `CCMS_PHASE_5) ? CCMS_MC_S0 : CCMS_MC_S5;
      default: return CCMS_MC_S0;
    endcase
  endfunction
endpackage

// [ccms_chan.sv]
// one capture/compare channel: pin steering, modulation and capture
`timescale 1ns/10ps
`include "ccms_regs.svh"
module ccms_chan (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // configuration: {modulation_select, channel_mode_code}
  input wire logic [3:0] cfg_in,
  input wire logic init_level_in,
  input wire ccms_pkg::ccms_tmr_s tmr_in,
  // compare and pin signals
  input wire logic cmp_pri_in,
  input wire logic cmp_compl_in,
  input wire logic mod_signal_in,
  input wire logic pin_pri_in,
  // results
  output ccms_pkg::ccms_pin_s pin_out,
  output ccms_pkg::ccms_cap_s cap_out
);
  ccms_pkg::ccms_chan_s s_q, s_d;
  ccms_pkg::ccms_mode_e mode;
  logic compl_sig;
  logic rise;
  logic fall;

  always_comb begin
    s_d = s_q;
    mode = ccms_pkg::ccms_mode_e'(cfg_in[2:0]);
    s_d.pin_prev = pin_pri_in;
    if (tmr_in.start) begin
      s_d.init_lvl = init_level_in;
    end
    compl_sig = cmp_compl_in;
    if (cfg_in[`CCMS_B_MODSEL]) begin
      // gate the fast compare signal into one phase of the channel signal
      compl_sig = mod_signal_in & (s_q.init_lvl ? ~cmp_pri_in : cmp_pri_in);
    end
    s_d.pin.pri_oe = ccms_pkg::drives_pri(mode);
    s_d.pin.pri_o = cmp_pri_in & ccms_pkg::drives_pri(mode);
    s_d.pin.compl_oe = ccms_pkg::drives_compl(mode);
    s_d.pin.compl_o = compl_sig & ccms_pkg::drives_compl(mode);
    rise = pin_pri_in & ~s_q.pin_prev;
    fall = ~pin_pri_in & s_q.pin_prev;
    s_d.cap.stb = (rise & ((mode == ccms_pkg::CCMS_CAP_RISE)
                        | (mode == ccms_pkg::CCMS_CAP_BOTH)))
                | (fall & ((mode == ccms_pkg::CCMS_CAP_FALL)
                        | (mode == ccms_pkg::CCMS_CAP_BOTH)));
    if (s_d.cap.stb) begin
      s_d.cap.value = tmr_in.value;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= '0;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign pin_out = s_q.pin;
  assign cap_out = s_q.cap;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_capture_idle: assert property (
    (ce_in && cfg_in[2:0] == 3'h4) |=> !cap_out.stb)
    else $error("capture fired with edges disabled");
  chk_rise_capture: assert property (
    (ce_in && cfg_in[2:0] == 3'h5 && pin_pri_in && !s_q.pin_prev)
    |=> cap_out.stb && cap_out.value == $past(tmr_in.value))
    else $error("rising edge did not capture the timer");
  chk_pin_release: assert property (
    (ce_in && cfg_in[2:0] == 3'h0) |=> !pin_out.pri_oe && !pin_out.compl_oe)
    else $error("disabled channel still drives a pin");
  cov_both_edges: cover property (
    (cfg_in[2:0] == 3'h7) ##1 cap_out.stb ##[1:20] cap_out.stb);
endmodule

// [ccms_top.sv]
// mode select registers, dead-time offset shadowing and multichannel stepping
// Behaviour
// - 16-bit offset in two shadowed bytes, reset zero
// - shadow moves to working on period/zero transfer
// - complementary match uses timer plus offset
// - period match steps pattern when software stepping off
// - software stepping on: only strobe steps pattern
// - strobed step applied when timer equals zero
// - strobe bit self-clears the following cycle
// - modulation select gates fast compare onto complement
// - initial level set: modulate during low phase
// - initial level clear: modulate during high phase
// - each channel has its own mode code
// - code 000 releases both pins
// - code 001 drives primary pin only
// - code 010 drives complementary pin only
// - code 011 drives both pins
// - code 100 capture with no edge trigger
// - code 101 captures on rising edge
// - code 110 captures on falling edge
// - code 111 captures on both edges
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`include "ccms_regs.svh"
module ccms_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ce_in,
  // register bus
  input wire ccms_pkg::ccms_apb_req_s apb_req_in,
  output ccms_pkg::ccms_apb_rsp_s apb_rsp_out,
  // compare timer status
  input wire ccms_pkg::ccms_tmr_s tmr_in,
  input wire logic [2:0] mc_phases_in,
  input wire logic [2:0] init_level_in,
  // channel compare signals and pins
  input wire logic [2:0] cmp_pri_in,
  input wire logic [2:0] cmp_compl_in,
  input wire logic mod_signal_in,
  input wire logic [2:0] pin_pri_in,
  // channel results
  output ccms_pkg::ccms_pin_s [2:0] pin_out,
  output ccms_pkg::ccms_cap_s [2:0] cap_out,
  // offset timer sum and multichannel state
  output logic [15:0] offset_sum_out,
  output logic [5:0] mc_state_out
);
  localparam ccms_pkg::ccms_top_s TOP_RST = '{
    apb: ccms_pkg::CCMS_APB_IDLE,
    rsp: '0,
    mode0: `CCMS_RST_BYTE,
    mode1: `CCMS_RST_BYTE,
    ofs_sh: `CCMS_RST_WORD,
    ofs_wk: `CCMS_RST_WORD,
    sum: `CCMS_RST_WORD,
    mc: ccms_pkg::CCMS_MC_S0,
    mc_pend: 1'b0
  };

  ccms_pkg::ccms_top_s s_q, s_d;
  logic [3:0] hit;
  logic [7:0] wdat;
  logic [11:0] chan_cfg;
  logic wr_fire;
  logic offs_xfer;
  logic zero_now;
  logic swmc;
  logic mc_step;
  logic strobe_set;

  // one-hot register select: {offset high, offset low, mode 1, mode 0}
  function automatic logic [3:0] reg_hit(input logic [11:0] a);
    reg_hit[0] = (a == `CCMS_BYTE_ADDR(`CCMS_IDX_MODE0));
    reg_hit[1] = (a == `CCMS_BYTE_ADDR(`CCMS_IDX_MODE1));
    reg_hit[2] = (a == `CCMS_BYTE_ADDR(`CCMS_IDX_OFS_LO));
    reg_hit[3] = (a == `CCMS_BYTE_ADDR(`CCMS_IDX_OFS_HI));
  endfunction

  // read view of the selected register; offsets read from the shadow
  function automatic logic [7:0] reg_read(input logic [3:0] h, input ccms_pkg::ccms_top_s s);
    reg_read = `CCMS_RST_BYTE;
    if (h[0]) begin
      reg_read = s.mode0;
    end
    if (h[1]) begin
      reg_read = s.mode1 & `CCMS_MODE1_MASK;
    end
    if (h[2]) begin
      reg_read = s.ofs_sh[7:0];
    end
    if (h[3]) begin
      reg_read = s.ofs_sh[15:8];
    end
  endfunction

  always_comb begin
    s_d = s_q;
    hit = reg_hit(apb_req_in.paddr);
    wdat = apb_req_in.pwdata[7:0];
    wr_fire = 1'b0;
    zero_now = (tmr_in.value == `CCMS_TMR_ZERO);
    swmc = s_q.mode1[`CCMS_B_SWMC];

    // zero-wait slave: answer in the first access cycle
    case (s_q.apb)
      ccms_pkg::CCMS_APB_IDLE: begin
        if (apb_req_in.psel && !apb_req_in.penable) begin
          s_d.apb = ccms_pkg::CCMS_APB_ACC;
          s_d.rsp.pready = 1'b1;
          s_d.rsp.pslverr = ~|hit;
          s_d.rsp.prdata = {`CCMS_RD_PAD, reg_read(hit, s_q)};
        end
      end
      ccms_pkg::CCMS_APB_ACC: begin
        if (apb_req_in.psel && apb_req_in.penable) begin
          s_d.apb = ccms_pkg::CCMS_APB_IDLE;
          s_d.rsp.pready = 1'b0;
          s_d.rsp.pslverr = 1'b0;
          // unmapped writes are answered with an error and dropped
          wr_fire = apb_req_in.pwrite && |hit;
        end
      end
      default: begin
        s_d.apb = ccms_pkg::CCMS_APB_IDLE;
        s_d.rsp.pready = 1'b0;
      end
    endcase

    // working offset only changes on a timer transfer event
    offs_xfer = tmr_in.shadow_en
              & (tmr_in.count_mode ? tmr_in.zero_hit : tmr_in.period_hit);
    if (offs_xfer) begin
      s_d.ofs_wk = s_q.ofs_sh;
    end
    s_d.sum = tmr_in.value + s_q.ofs_wk;

    if (s_q.mode1[`CCMS_B_NEXT]) begin
      s_d.mode1[`CCMS_B_NEXT] = 1'b0;
    end

    // pattern step source depends on software stepping enable
    mc_step = swmc ? (s_q.mc_pend & zero_now) : tmr_in.period_hit;
    if (mc_step) begin
      s_d.mc = ccms_pkg::mc_next(s_q.mc, mc_phases_in);
      s_d.mc_pend = 1'b0;
    end
    if (!swmc) begin
      s_d.mc_pend = 1'b0;
    end

    strobe_set = wr_fire & hit[1] & wdat[`CCMS_B_NEXT] & wdat[`CCMS_B_SWMC];
    if (wr_fire) begin
      if (hit[0]) begin
        s_d.mode0 = wdat;
      end
      if (hit[1]) begin
        s_d.mode1 = wdat & `CCMS_MODE1_MASK;
      end
      if (hit[2]) begin
        s_d.ofs_sh[7:0] = wdat;
      end
      if (hit[3]) begin
        s_d.ofs_sh[15:8] = wdat;
      end
    end
    // a new strobe wins over the consumption of an older one
    if (strobe_set) begin
      s_d.mc_pend = 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_q <= TOP_RST;
    end else if (ce_in) begin
      s_q <= s_d;
    end
  end

  assign chan_cfg = {s_q.mode1[`CCMS_CH_W-1:0], s_q.mode0};

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_chan
      ccms_chan u_chan (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .cfg_in(chan_cfg[ch*`CCMS_CH_W +: `CCMS_CH_W]),
        .init_level_in(init_level_in[ch]),
        .tmr_in(tmr_in),
        .cmp_pri_in(cmp_pri_in[ch]),
        .cmp_compl_in(cmp_compl_in[ch]),
        .mod_signal_in(mod_signal_in),
        .pin_pri_in(pin_pri_in[ch]),
        .pin_out(pin_out[ch]),
        .cap_out(cap_out[ch])
      );
    end
  endgenerate

  assign apb_rsp_out = s_q.rsp;
  assign offset_sum_out = s_q.sum;
  assign mc_state_out = s_q.mc;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_strobe_autoclear: assert property (
    (ce_in && s_q.mode1[`CCMS_B_NEXT]) |=> !s_q.mode1[`CCMS_B_NEXT])
    else $error("next-state strobe not cleared after one cycle");

  chk_offset_hold: assert property (
    (ce_in && !offs_xfer) |=> $stable(s_q.ofs_wk))
    else $error("working offset changed without a transfer");

  chk_offset_load: assert property (
    (ce_in && offs_xfer) |=> s_q.ofs_wk == $past(s_q.ofs_sh))
    else $error("working offset not loaded from shadow");

  chk_offset_sum: assert property (
    ce_in |=> offset_sum_out == 16'($past(tmr_in.value) + $past(s_q.ofs_wk)))
    else $error("offset sum wrong");

  chk_period_step: assert property (
    (ce_in && !swmc && tmr_in.period_hit)
    |=> mc_state_out == ccms_pkg::mc_next($past(s_q.mc), $past(mc_phases_in)))
    else $error("period match did not step the pattern");

  chk_sw_hold: assert property (
    (ce_in && swmc && !(s_q.mc_pend && zero_now)) |=> $stable(mc_state_out))
    else $error("pattern stepped without an applied strobe");

  chk_strobe_apply: assert property (
    (ce_in && swmc && s_q.mc_pend && zero_now) |=> mc_state_out != $past(mc_state_out))
    else $error("pending strobe not applied at timer zero");

  chk_apb_ready: assert property (
    (ce_in && s_q.apb == ccms_pkg::CCMS_APB_IDLE && apb_req_in.psel && !apb_req_in.penable)
    |=> apb_rsp_out.pready)
    else $error("slave did not answer in the first access cycle");

  cov_strobe_write: cover property (strobe_set ##[1:50] mc_step);
  cov_offset_xfer: cover property (offs_xfer && s_q.ofs_sh != s_q.ofs_wk);
  cov_period_wrap: cover property (!swmc && tmr_in.period_hit && s_q.mc == ccms_pkg::CCMS_MC_S5);
endmodule

// [ccms_pin_model.sv]
// far-side model of the channel pins: external sources meet the block's drivers
`timescale 1ns/10ps
module ccms_pin_model (
  // pins driven by the block
  input wire ccms_pkg::ccms_pin_s [2:0] pin_in,
  // levels of the outside sources
  input wire logic [2:0] ext_level_in,
  // resolved primary pin levels
  output logic [2:0] pri_level_out
);
  // block wins while it drives, otherwise the outside source sets the level
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pri_level_out[i] = pin_in[i].pri_oe ? pin_in[i].pri_o : ext_level_in[i];
    end
  end
endmodule

// [ccms_tb.sv]
// self-checking bench of the mode select and offset block
`timescale 1ns/10ps
module testbench;
  logic clk_in, rst_b_in, err, mod_sig, ce;
  ccms_pkg::ccms_apb_req_s req;
  ccms_pkg::ccms_apb_rsp_s rsp;
  ccms_pkg::ccms_tmr_s tmr;
  logic [2:0] phases, init_lvl, cmp_pri, cmp_compl, pin_pri, ext;
  ccms_pkg::ccms_pin_s [2:0] pins;
  ccms_pkg::ccms_cap_s [2:0] caps;
  logic [15:0] sum, cap_exp;
  logic [5:0] mc, mc_exp;
  logic [31:0] rd;
  int num_errors = 0;
  int num_checks = 0;
  int n_cap = 0;
  int cnt_exp = 0;
  logic [11:0] r_addr [6] = '{12'h38c, 12'h390, 12'h390, 12'h398, 12'h39c, 12'h3a0};
  logic [7:0] r_pre [6] = '{8'h00, 8'h00, 8'h0f, 8'h00, 8'h00, 8'h00};
  logic [7:0] r_wr [6] = '{8'ha5, 8'h0f, 8'hc3, 8'h5a, 8'ha5, 8'h77};
  logic [7:0] r_exp [6] = '{8'ha5, 8'h0f, 8'h03, 8'h5a, 8'ha5, 8'h00};
  logic r_err [6] = '{1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
  // rows of {initial level, primary compare, modulator, expected complement}
  logic [3:0] m_row [5] = '{4'hb, 4'he, 4'h7, 4'h2, 4'h4};

  ccms_top DUT (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .ce_in(ce),
    .apb_req_in(req),
    .apb_rsp_out(rsp),
    .tmr_in(tmr),
    .mc_phases_in(phases),
    .init_level_in(init_lvl),
    .cmp_pri_in(cmp_pri),
    .cmp_compl_in(cmp_compl),
    .mod_signal_in(mod_sig),
    .pin_pri_in(pin_pri),
    .pin_out(pins),
    .cap_out(caps),
    .offset_sum_out(sum),
    .mc_state_out(mc)
  );

  ccms_pin_model pin_far (
    .pin_in(pins),
    .ext_level_in(ext),
    .pri_level_out(pin_pri)
  );

  initial begin
    clk_in = 1'h0;
    forever #50 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    if (caps[0].stb === 1'h1) n_cap <= n_cap + 1;
  end

  task wrap_up;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t flag %b expected %b", $time, got, exp);
    end
  endtask

  // request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_in);
    req <= '{1'h1, 1'h0, wr, a, {24'h00_0000, d}};
    @(posedge clk_in);
    req.penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_in);
      if (rsp.pready === 1'h1) break;
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    if (n == 20) num_errors++;
    req.psel <= 1'h0;
    req.penable <= 1'h0;
  endtask

  task hit(input logic p, input logic z, input logic s);
    @(posedge clk_in);
    tmr.period_hit <= p;
    tmr.zero_hit <= z;
    tmr.start <= s;
    @(posedge clk_in);
    tmr.period_hit <= 1'h0;
    tmr.zero_hit <= 1'h0;
    tmr.start <= 1'h0;
  endtask

  task settle;
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    num_errors++;
    wrap_up;
  end

  initial begin
    rst_b_in = 1'h0;
    ce = 1'h1;
    req = '0;
    tmr = '0;
    phases = 3'h4;
    init_lvl = 3'h0;
    cmp_pri = 3'h0;
    cmp_compl = 3'h0;
    ext = 3'h0;
    mod_sig = 1'h0;
    cap_exp = 16'h0000;
    repeat (12) @(posedge clk_in);
    rst_b_in <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      apb(1'h0, r_addr[i], 8'h00);
      chk_val(rd, {24'h00_0000, r_pre[i]});
      apb(1'h1, r_addr[i], r_wr[i]);
      chk_bit(err, r_err[i]);
      apb(1'h0, r_addr[i], 8'h00);
      chk_val(rd, {24'h00_0000, r_exp[i]});
      chk_bit(err, r_err[i]);
    end
    // compare modes on channel 0, channel 1 kept driving both pins
    @(posedge clk_in);
    // channel 1 primary low, complement high: a swapped pin path shows up
    cmp_pri <= 3'h5;
    cmp_compl <= 3'h7;
    for (int c = 0; c < 4; c++) begin
      apb(1'h1, 12'h38c, {4'h3, 1'h0, c[2:0]});
      settle;
      chk_bit(pins[0].pri_oe, c == 1 || c == 3);
      chk_bit(pins[0].compl_oe, c >= 2);
      if (c[0]) chk_bit(pins[0].pri_o, 1'h1);
      if (c >= 2) chk_bit(pins[0].compl_o, 1'h1);
      chk_bit(pins[1].compl_oe, 1'h1);
      chk_bit(pins[1].pri_o, 1'h0);
      chk_bit(pins[1].compl_o, 1'h1);
    end
    // capture edges: the pin rises, then falls, at distinct timer values
    for (int c = 4; c < 8; c++) begin
      apb(1'h1, 12'h38c, {5'h00, c[2:0]});
      settle;
      @(posedge clk_in);
      tmr.value <= 16'h0200 + c[15:0];
      ext[0] <= 1'h1;
      settle;
      @(posedge clk_in);
      tmr.value <= 16'h0300 + c[15:0];
      ext[0] <= 1'h0;
      settle;
      if (c == 5) cap_exp = 16'h0205;
      if (c >= 6) cap_exp = 16'h0300 + c[15:0];
      cnt_exp += (c == 7) ? 2 : (c > 4);
      chk_val(n_cap, cnt_exp);
      chk_val(caps[0].value, cap_exp);
    end
    // mode is set before any timer start
    apb(1'h1, 12'h38c, 8'h0a);
    for (int r = 0; r < 5; r++) begin
      @(posedge clk_in);
      init_lvl[0] <= m_row[r][3];
      hit(1'h0, 1'h0, 1'h1);
      @(posedge clk_in);
      cmp_pri[0] <= m_row[r][2];
      mod_sig <= m_row[r][1];
      settle;
      chk_bit(pins[0].compl_o, m_row[r][0]);
    end
    // period stepping for every pattern length
    mc_exp = 6'h01;
    for (int p = 4; p < 7; p++) begin
      @(posedge clk_in);
      phases <= p[2:0];
      for (int i = 0; i < p; i++) begin
        hit(1'h1, 1'h0, 1'h0);
        settle;
        mc_exp = (mc_exp == (6'h01 << (p - 1))) ? 6'h01 : mc_exp << 1;
        chk_val(mc, mc_exp);
      end
    end
    apb(1'h1, 12'h390, 8'h10);
    hit(1'h1, 1'h0, 1'h0);
    settle;
    chk_val(mc, 6'h01);
    @(posedge clk_in);
    tmr.value <= 16'h0005;
    apb(1'h1, 12'h390, 8'h30);
    settle;
    chk_val(mc, 6'h01);
    apb(1'h0, 12'h390, 8'h00);
    chk_val(rd, 32'h0000_0010);
    @(posedge clk_in);
    tmr.value <= 16'h0000;
    settle;
    chk_val(mc, 6'h02);
    // offset shadow: loaded by bus, moved only by the selected timer event
    @(posedge clk_in);
    tmr.value <= 16'h0100;
    tmr.shadow_en <= 1'h1;
    apb(1'h1, 12'h398, 8'h34);
    apb(1'h1, 12'h39c, 8'h12);
    hit(1'h0, 1'h1, 1'h0);
    settle;
    chk_val(sum, 16'h0100);
    hit(1'h1, 1'h0, 1'h0);
    settle;
    chk_val(sum, 16'h1334);
    @(posedge clk_in);
    tmr.count_mode <= 1'h1;
    apb(1'h1, 12'h398, 8'h00);
    hit(1'h1, 1'h0, 1'h0);
    settle;
    chk_val(sum, 16'h1334);
    hit(1'h0, 1'h1, 1'h0);
    settle;
    chk_val(sum, 16'h1300);
    // clock enable low freezes the offset sum
    @(posedge clk_in);
    ce <= 1'h0;
    tmr.value <= 16'h0200;
    settle;
    chk_val(sum, 16'h1300);
    @(posedge clk_in);
    ce <= 1'h1;
    settle;
    chk_val(sum, 16'h1400);
    // second reset in mid-run
    @(posedge clk_in);
    rst_b_in <= 1'h0;
    @(negedge clk_in);
    chk_val(mc, 6'h01);
    chk_val(sum, 16'h0000);
    chk_bit(pins[0].compl_oe, 1'h0);
    @(posedge clk_in);
    rst_b_in <= 1'h1;
    apb(1'h0, 12'h39c, 8'h00);
    chk_val(rd, 32'h0000_0000);
    wrap_up;
  end
endmodule
